// file: src/bsw_pkg.sv
// package: register map, field layout and event encodings of the bridge window block
package bsw_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] SEC_STATUS_OFFSET = 8'h1C;
    localparam logic [7:0] MEM_WINDOW_OFFSET = 8'h20;
    localparam logic [7:0] PF_WINDOW_OFFSET = 8'h24;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h40;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h44;
    localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h48;
    localparam logic [7:0] MODE_OFFSET = 8'h4C;
    localparam int RX_TABORT_BIT = 28;
    localparam int RX_MABORT_BIT = 29;
    localparam int RX_SERR_BIT = 30;
    localparam int PARITY_BIT = 31;
    localparam int FLAG_LO = 28;
    localparam int FLAG_HI = 31;
    localparam int BASE_LO = 4;
    localparam int BASE_HI = 15;
    localparam int LIMIT_LO = 20;
    localparam int LIMIT_HI = 31;
    localparam int NFLAG = 4;
    localparam logic [19:0] BASE_LOW_FILL = 20'h00000;
    localparam logic [19:0] LIMIT_LOW_FILL = 20'hFFFFF;
    localparam logic [31:0] MEM_WINDOW_RESET = 32'h00000000;
    localparam logic [31:0] PF_WINDOW_RESET = 32'h00000000;
    localparam logic [31:0] WINDOW_MASK = 32'hFFF0FFF0;
    localparam logic [3:0] FLAG_RESET = 4'h0;
    // event input vector positions
    localparam int EV_FWD_TABORT = 0;
    localparam int EV_FWD_SPLIT_TABORT = 1;
    localparam int EV_REV_CA_CPL = 2;
    localparam int EV_FWD_MABORT = 3;
    localparam int EV_REV_UR_CPL = 4;
    localparam int EV_FWD_SERR_OUT = 5;
    localparam int EV_REV_ERR_MSG = 6;
    localparam int EV_FWD_ADDR_PERR = 7;
    localparam int EV_FWD_WR_DPERR = 8;
    localparam int EV_FWD_RD_DPERR = 9;
    localparam int EV_REV_POISON = 10;
    localparam int EV_REV_BAD_ECRC = 11;
    localparam int NEV = 12;
    typedef enum logic [1:0] {
        BSW_IDLE, BSW_ACCESS
    } bsw_apb_state_type;
endpackage

// file: src/bsw_flag_bank.sv
// sticky flag bank: set by hardware, cleared by write-one, set wins
`timescale 1ns/1ps
module bsw_flag_bank #(
    parameter int WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    output logic [WIDTH-1:0] flags
);
    import bsw_pkg::*;
    logic [WIDTH-1:0] flags_ff;
    logic [WIDTH-1:0] nxt_flags;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gen_bit
            assign nxt_flags[g] = set_in[g] | (flags_ff[g] & ~clr_in[g]);
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= WIDTH'(FLAG_RESET);
        end else begin
            flags_ff <= nxt_flags;
        end
    end
    assign flags = flags_ff;
endmodule

// file: src/bsw_top.sv
// secondary status error flags and non-prefetchable memory window over APB
//
// Functional notes
// - forward: target abort as master sets 28
// - reverse: completer abort completion sets 28
// - forward: master abort as master sets 29
// - reverse: unsupported request completion sets 29
// - forward: driving system error sets 30
// - reverse: fatal/nonfatal error message sets 30
// - forward: address/attribute parity error sets 31
// - forward: write/split target data parity sets 31
// - forward: read master data parity sets 31
// - parity flag ignores parity response enable
// - reverse: poisoned or bad-ECRC TLP sets 31
// - base field 15:4, low bits zero
// - limit field 31:20, low bits ones
// - prefetchable traffic uses separate window register
`timescale 1ns/1ps
module bsw_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bsw_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [bsw_pkg::NEV-1:0] event_in,
    input wire logic parity_resp_en,
    input wire logic [31:0] lookup_addr,
    input wire logic lookup_prefetch,
    output logic lookup_hit,
    output logic irq
);
    import bsw_pkg::*;

    logic reverse_mode_ff;
    logic [31:0] mem_window_ff;
    logic [31:0] pf_window_ff;
    logic [NFLAG-1:0] irq_en_ff;
    logic [NFLAG-1:0] irq_stat_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic lookup_hit_ff;
    logic irq_ff;
    logic [NFLAG-1:0] flag_set;
    logic [NFLAG-1:0] flag_clr;
    logic [NFLAG-1:0] irq_clr;
    logic [NFLAG-1:0] flags;
    logic [31:0] nxt_prdata;
    logic nxt_slverr;
    logic wr_acc;
    logic rd_acc;
    logic [NEV-1:0] ev;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == SEC_STATUS_OFFSET) || (a == MEM_WINDOW_OFFSET) ||
                    (a == PF_WINDOW_OFFSET) || (a == IRQ_STATUS_OFFSET) ||
                    (a == IRQ_ENABLE_OFFSET) || (a == IRQ_CLEAR_OFFSET) ||
                    (a == MODE_OFFSET);
    endfunction

    function automatic logic in_window(input logic [31:0] win,
                                       input logic [31:0] a);
        logic [31:0] lo;
        logic [31:0] hi;
        lo = {win[BASE_HI:BASE_LO], BASE_LOW_FILL};
        hi = {win[LIMIT_HI:LIMIT_LO], LIMIT_LOW_FILL};
        in_window = (a >= lo) && (a <= hi);
    endfunction

    // event inputs come from secondary bus logic on this clock
    assign ev = event_in;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;

    // per-mode event selection; parity enable deliberately unused
    always_comb begin
        flag_set = '0;
        if (!reverse_mode_ff) begin
            flag_set[RX_TABORT_BIT-FLAG_LO] = ev[EV_FWD_TABORT] |
                ev[EV_FWD_SPLIT_TABORT];
            flag_set[RX_MABORT_BIT-FLAG_LO] = ev[EV_FWD_MABORT];
            flag_set[RX_SERR_BIT-FLAG_LO] = ev[EV_FWD_SERR_OUT];
            flag_set[PARITY_BIT-FLAG_LO] = ev[EV_FWD_ADDR_PERR] |
                ev[EV_FWD_WR_DPERR] |
                ev[EV_FWD_RD_DPERR];
        end else begin
            flag_set[RX_TABORT_BIT-FLAG_LO] = ev[EV_REV_CA_CPL];
            flag_set[RX_MABORT_BIT-FLAG_LO] = ev[EV_REV_UR_CPL];
            flag_set[RX_SERR_BIT-FLAG_LO] = ev[EV_REV_ERR_MSG];
            flag_set[PARITY_BIT-FLAG_LO] = ev[EV_REV_POISON] |
                ev[EV_REV_BAD_ECRC];
        end
    end

    assign flag_clr = (wr_acc && paddr == SEC_STATUS_OFFSET) ?
        pwdata[FLAG_HI:FLAG_LO] : '0;
    assign irq_clr = (wr_acc && paddr == IRQ_CLEAR_OFFSET) ?
        pwdata[NFLAG-1:0] : '0;

    bsw_flag_bank #(.WIDTH(NFLAG)) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set_in(flag_set),
        .clr_in(flag_clr),
        .flags(flags)
    );

    // interrupt status mirrors events, own clear register, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= FLAG_RESET;
        end else begin
            irq_stat_ff <= flag_set | (irq_stat_ff & ~irq_clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |((flag_set | (irq_stat_ff & ~irq_clr)) & irq_en_ff);
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_window_ff <= MEM_WINDOW_RESET;
            pf_window_ff <= PF_WINDOW_RESET;
            irq_en_ff <= FLAG_RESET;
            reverse_mode_ff <= 1'b0;
        end else if (wr_acc) begin
            if (paddr == MEM_WINDOW_OFFSET) begin
                mem_window_ff <= pwdata & WINDOW_MASK;
            end
            if (paddr == PF_WINDOW_OFFSET) begin
                pf_window_ff <= pwdata & WINDOW_MASK;
            end
            if (paddr == IRQ_ENABLE_OFFSET) begin
                irq_en_ff <= pwdata[NFLAG-1:0];
            end
            if (paddr == MODE_OFFSET) begin
                reverse_mode_ff <= pwdata[0];
            end
        end
    end

    // read mux
    always_comb begin
        nxt_prdata = '0;
        nxt_slverr = 1'b0;
        if (!is_mapped(paddr)) begin
            nxt_slverr = 1'b1;
        end else if (paddr == SEC_STATUS_OFFSET) begin
            nxt_prdata[FLAG_HI:FLAG_LO] = flags;
        end else if (paddr == MEM_WINDOW_OFFSET) begin
            nxt_prdata = mem_window_ff & WINDOW_MASK;
        end else if (paddr == PF_WINDOW_OFFSET) begin
            nxt_prdata = pf_window_ff;
        end else if (paddr == IRQ_STATUS_OFFSET) begin
            nxt_prdata[NFLAG-1:0] = irq_stat_ff;
        end else if (paddr == IRQ_ENABLE_OFFSET) begin
            nxt_prdata[NFLAG-1:0] = irq_en_ff;
        end else if (paddr == MODE_OFFSET) begin
            nxt_prdata[0] = reverse_mode_ff;
        end
    end

    // zero-wait slave: pready registered from the setup cycle, high in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= psel & ~penable;
            pslverr_ff <= psel & ~penable & nxt_slverr;
            prdata_ff <= (psel & ~penable & ~pwrite) ? nxt_prdata : '0;
        end
    end

    // window lookup: prefetchable traffic checks its own register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lookup_hit_ff <= 1'b0;
        end else begin
            lookup_hit_ff <= lookup_prefetch ?
                in_window(pf_window_ff, lookup_addr) :
                in_window(mem_window_ff, lookup_addr);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign lookup_hit = lookup_hit_ff;
    assign irq = irq_ff;

    AST_FWD_TABORT: assert property (
        @(posedge pclk) disable iff (!presetn)
        !reverse_mode_ff && (ev[EV_FWD_TABORT] || ev[EV_FWD_SPLIT_TABORT])
        |=> flags[RX_TABORT_BIT-FLAG_LO])
        else $error("fwd target abort not flagged");
    AST_REV_CA: assert property (
        @(posedge pclk) disable iff (!presetn)
        reverse_mode_ff && ev[EV_REV_CA_CPL]
        |=> flags[RX_TABORT_BIT-FLAG_LO])
        else $error("rev completer abort not flagged");
    AST_FWD_MABORT: assert property (
        @(posedge pclk) disable iff (!presetn)
        !reverse_mode_ff && ev[EV_FWD_MABORT]
        |=> flags[RX_MABORT_BIT-FLAG_LO])
        else $error("fwd master abort not flagged");
    AST_REV_UR: assert property (
        @(posedge pclk) disable iff (!presetn)
        reverse_mode_ff && ev[EV_REV_UR_CPL]
        |=> flags[RX_MABORT_BIT-FLAG_LO])
        else $error("rev UR not flagged");
    AST_FWD_SERR: assert property (
        @(posedge pclk) disable iff (!presetn)
        !reverse_mode_ff && ev[EV_FWD_SERR_OUT]
        |=> flags[RX_SERR_BIT-FLAG_LO])
        else $error("fwd serr not flagged");
    AST_REV_ERRMSG: assert property (
        @(posedge pclk) disable iff (!presetn)
        reverse_mode_ff && ev[EV_REV_ERR_MSG]
        |=> flags[RX_SERR_BIT-FLAG_LO])
        else $error("rev error message not flagged");
    AST_FWD_APERR: assert property (
        @(posedge pclk) disable iff (!presetn)
        !reverse_mode_ff && ev[EV_FWD_ADDR_PERR]
        |=> flags[PARITY_BIT-FLAG_LO])
        else $error("addr parity not flagged");
    AST_FWD_WPERR: assert property (
        @(posedge pclk) disable iff (!presetn)
        !reverse_mode_ff && ev[EV_FWD_WR_DPERR]
        |=> flags[PARITY_BIT-FLAG_LO])
        else $error("write data parity not flagged");
    AST_FWD_RPERR: assert property (
        @(posedge pclk) disable iff (!presetn)
        !reverse_mode_ff && ev[EV_FWD_RD_DPERR]
        |=> flags[PARITY_BIT-FLAG_LO])
        else $error("read data parity not flagged");
    AST_PERR_NOEN: assert property (
        @(posedge pclk) disable iff (!presetn)
        !parity_resp_en && ((!reverse_mode_ff && ev[EV_FWD_WR_DPERR]) ||
        (reverse_mode_ff && ev[EV_REV_POISON]))
        |=> flags[PARITY_BIT-FLAG_LO])
        else $error("parity flag gated by enable");
    AST_REV_POISON: assert property (
        @(posedge pclk) disable iff (!presetn)
        reverse_mode_ff && (ev[EV_REV_POISON] || ev[EV_REV_BAD_ECRC])
        |=> flags[PARITY_BIT-FLAG_LO])
        else $error("poison/ecrc not flagged");
    AST_FWD_IGNORE: assert property (
        @(posedge pclk) disable iff (!presetn)
        !reverse_mode_ff && !flags[RX_TABORT_BIT-FLAG_LO] &&
        !ev[EV_FWD_TABORT] && !ev[EV_FWD_SPLIT_TABORT]
        |=> !flags[RX_TABORT_BIT-FLAG_LO])
        else $error("target abort flag set by wrong event");
    AST_REV_IGNORE: assert property (
        @(posedge pclk) disable iff (!presetn)
        reverse_mode_ff && !flags[PARITY_BIT-FLAG_LO] &&
        !ev[EV_REV_POISON] && !ev[EV_REV_BAD_ECRC]
        |=> !flags[PARITY_BIT-FLAG_LO])
        else $error("parity flag set by wrong event");
    AST_CLR_FLAG: assert property (
        @(posedge pclk) disable iff (!presetn)
        flag_clr[RX_TABORT_BIT-FLAG_LO] && !flag_set[RX_TABORT_BIT-FLAG_LO]
        |=> !flags[RX_TABORT_BIT-FLAG_LO])
        else $error("write one did not clear flag");
    AST_WIN_WRITE: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == MEM_WINDOW_OFFSET
        |=> mem_window_ff == ($past(pwdata) & WINDOW_MASK))
        else $error("window write not stored");
    AST_BASE_HIT: assert property (
        @(posedge pclk) disable iff (!presetn)
        !lookup_prefetch && lookup_addr ==
        {mem_window_ff[BASE_HI:BASE_LO], BASE_LOW_FILL} &&
        mem_window_ff[BASE_HI:BASE_LO] <= mem_window_ff[LIMIT_HI:LIMIT_LO]
        |=> lookup_hit)
        else $error("base address not a hit");
    AST_LIMIT_HIT: assert property (
        @(posedge pclk) disable iff (!presetn)
        !lookup_prefetch && lookup_addr ==
        {mem_window_ff[LIMIT_HI:LIMIT_LO], LIMIT_LOW_FILL} &&
        mem_window_ff[BASE_HI:BASE_LO] <= mem_window_ff[LIMIT_HI:LIMIT_LO]
        |=> lookup_hit)
        else $error("limit address not a hit");
    AST_MEM_BELOW: assert property (
        @(posedge pclk) disable iff (!presetn)
        !lookup_prefetch &&
        lookup_addr < {mem_window_ff[BASE_HI:BASE_LO], BASE_LOW_FILL}
        |=> !lookup_hit)
        else $error("address below base is a hit");
    AST_MEM_ABOVE: assert property (
        @(posedge pclk) disable iff (!presetn)
        !lookup_prefetch &&
        lookup_addr > {mem_window_ff[LIMIT_HI:LIMIT_LO], LIMIT_LOW_FILL}
        |=> !lookup_hit)
        else $error("address above limit is a hit");
    AST_PF_SEP: assert property (
        @(posedge pclk) disable iff (!presetn)
        lookup_prefetch &&
        (lookup_addr < {pf_window_ff[BASE_HI:BASE_LO], BASE_LOW_FILL} ||
        lookup_addr > {pf_window_ff[LIMIT_HI:LIMIT_LO], LIMIT_LOW_FILL})
        |=> !lookup_hit)
        else $error("prefetch lookup used wrong window");
    AST_PF_HIT: assert property (
        @(posedge pclk) disable iff (!presetn)
        lookup_prefetch &&
        lookup_addr >= {pf_window_ff[BASE_HI:BASE_LO], BASE_LOW_FILL} &&
        lookup_addr <= {pf_window_ff[LIMIT_HI:LIMIT_LO], LIMIT_LOW_FILL}
        |=> lookup_hit)
        else $error("prefetch window address not a hit");
    AST_RSVD_ZERO: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready && !pslverr && $past(paddr) == MEM_WINDOW_OFFSET
        |-> (prdata & ~WINDOW_MASK) == '0)
        else $error("reserved window bits not zero");
    AST_STATUS_READ: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready && psel && !pwrite && paddr == SEC_STATUS_OFFSET
        |-> prdata[FLAG_HI:FLAG_LO] == $past(flags) &&
        prdata[FLAG_LO-1:0] == '0)
        else $error("status read data wrong");
    AST_PREADY_ONE: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_SLVERR_PAIR: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RD_IDLE_ZERO: assert property (
        @(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == '0)
        else $error("read data outside access cycle");
    AST_IRQ_NEEDS_STAT: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq |-> irq_stat_ff != '0)
        else $error("interrupt without status bit");

    COV_FWD_PERR: cover property (@(posedge pclk) disable iff (!presetn)
        !reverse_mode_ff && flag_set[PARITY_BIT-FLAG_LO]);
    COV_REV_TABORT: cover property (@(posedge pclk) disable iff (!presetn)
        reverse_mode_ff && flag_set[RX_TABORT_BIT-FLAG_LO]);
    COV_SET_CLR: cover property (@(posedge pclk) disable iff (!presetn)
        flag_set[RX_MABORT_BIT-FLAG_LO] && flag_clr[RX_MABORT_BIT-FLAG_LO]);
    COV_HIT: cover property (@(posedge pclk) disable iff (!presetn)
        lookup_hit);
    COV_UNMAPPED: cover property (@(posedge pclk) disable iff (!presetn)
        pslverr);
endmodule

// file: verif/bsw_agent.sv
// secondary bus agent model: emits one-cycle error events on request
`timescale 1ns/1ps
module bsw_agent (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic [3:0] idx,
    output logic [bsw_pkg::NEV-1:0] event_in
);
    import bsw_pkg::*;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_in <= '0;
        end else begin
            event_in <= fire ? (12'h001 << idx) : 12'h000;
        end
    end
endmodule

// file: verif/testbench.sv
// self-checking bench for the secondary status flags and memory window
`timescale 1ns/1ps
module testbench;
    import bsw_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, fire, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, lookup_addr, rd;
    logic pready, pslverr, parity_resp_en, lookup_prefetch, lookup_hit, irq;
    logic [3:0] idx;
    logic [NEV-1:0] event_in;
    int error_cnt, compares;
    // status bit and mode (1 reverse) of each event input
    int ev_bit [NEV] = '{28, 28, 28, 29, 29, 30, 30, 31, 31, 31, 31, 31};
    logic ev_rev [NEV] = '{0, 0, 1, 0, 1, 0, 1, 0, 0, 0, 1, 1};

    bsw_top bsw_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_in(event_in), .parity_resp_en(parity_resp_en),
        .lookup_addr(lookup_addr), .lookup_prefetch(lookup_prefetch),
        .lookup_hit(lookup_hit), .irq(irq));
    bsw_agent bsw_agent_inst (.pclk(pclk), .presetn(presetn), .fire(fire),
        .idx(idx), .event_in(event_in));

    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, prdata and pslverr are taken at the same rising edge
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                break;
            end
        end
        if (n == 20) begin
            error_cnt++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [3:0] k);
        @(posedge pclk);
        fire <= 1'b1;
        idx <= k;
        @(posedge pclk);
        fire <= 1'b0;
    endtask
    task automatic look(input logic [31:0] a, input logic pf,
                        input logic exp);
        @(posedge pclk);
        lookup_addr <= a;
        lookup_prefetch <= pf;
        @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, lookup_hit}, {31'h0, exp});
    endtask

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fire = 1'b0;
        idx = 4'h0;
        parity_resp_en = 1'b0;
        lookup_addr = '0;
        lookup_prefetch = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, SEC_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, MEM_WINDOW_OFFSET, 32'h0);
        chk(rd, MEM_WINDOW_RESET);
        $display("test reset done");
        for (int i = 0; i < NEV; i++) begin
            parity_resp_en <= i[0];
            apb(1'b1, MODE_OFFSET, {31'h0, ev_rev[i]});
            pulse(i[3:0]);
            apb(1'b0, SEC_STATUS_OFFSET, 32'h0);
            chk(rd, 32'h1 << ev_bit[i]);
            apb(1'b1, SEC_STATUS_OFFSET, 32'h1 << ev_bit[i]);
            apb(1'b0, SEC_STATUS_OFFSET, 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, MODE_OFFSET, {31'h0, ~ev_rev[i]});
            pulse(i[3:0]);
            apb(1'b0, SEC_STATUS_OFFSET, 32'h0);
            chk(rd, 32'h0);
        end
        $display("test events done");
        apb(1'b1, MEM_WINDOW_OFFSET, 32'hFFFFFFFF);
        apb(1'b0, MEM_WINDOW_OFFSET, 32'h0);
        chk(rd, 32'hFFF0FFF0);
        apb(1'b1, MEM_WINDOW_OFFSET, 32'h4567123F);
        apb(1'b0, MEM_WINDOW_OFFSET, 32'h0);
        chk(rd, 32'h45601230);
        look(32'h12300000, 1'b0, 1'b1);
        look(32'h122FFFFF, 1'b0, 1'b0);
        look(32'h456FFFFF, 1'b0, 1'b1);
        look(32'h45700000, 1'b0, 1'b0);
        look(32'h12300000, 1'b1, 1'b0);
        look(32'h000FFFFF, 1'b1, 1'b1);
        apb(1'b1, PF_WINDOW_OFFSET, 32'h00F00010);
        apb(1'b0, PF_WINDOW_OFFSET, 32'h0);
        chk(rd, 32'h00F00010);
        chk({31'h0, err}, 32'h0);
        look(32'h00100000, 1'b1, 1'b1);
        look(32'h00100000, 1'b0, 1'b0);
        // event and write-one clear land on the same edge: set wins
        fork
            apb(1'b1, SEC_STATUS_OFFSET, 32'h20000000);
            pulse(4'h3);
        join
        apb(1'b0, SEC_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h20000000);
        apb(1'b1, SEC_STATUS_OFFSET, 32'h20000000);
        apb(1'b0, SEC_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h0);
        $display("test window done");
        apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h0000000F);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, IRQ_ENABLE_OFFSET, 32'h00000001);
        @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, IRQ_CLEAR_OFFSET, 32'h0000000F);
        apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h80, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("test irq and unmapped done");
        stop_test();
    end
endmodule
